// ==== hdl/smbus_pkg.sv ====
// Shared constants and types for the two-wire bus master block.
// Assumes a register port on ref_clk and a free-running link clock for the pin logic.
package smbus_pkg;
  localparam int ADDR_W = 2;
  localparam logic [ADDR_W-1:0] CTRL_STATUS_OFS = 2'h0;
  localparam logic [ADDR_W-1:0] SERIAL_BYTE_OFS = 2'h1;
  localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
  localparam logic [7:0] SERIAL_BYTE_RESET = 8'h00;
  localparam int POS_MASTER = 7;
  localparam int POS_TRANSMIT_DIRECTION_FLAG = 6;
  localparam int POS_START = 5;
  localparam int POS_STOP = 4;
  localparam int POS_ACK_REQUEST_FLAG = 3;
  localparam int POS_ARBITRATION_LOST_FLAG = 2;
  localparam int POS_ACK = 1;
  localparam int POS_SI = 0;
  localparam int RX_BITS = 8;
  localparam int TX_BITS = 9;
  localparam int ACK_BITS = 1;
  localparam int BUS_IDLE_TIMEOUT_US = 50;
  localparam int LINK_CLK_PERIOD_NS = 64;
  localparam int BUS_IDLE_TIMEOUT_CYC =
    (BUS_IDLE_TIMEOUT_US * 1000 + LINK_CLK_PERIOD_NS - 1) / LINK_CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    CMD_START = 3'h0,
    CMD_STOP = 3'h1,
    CMD_STOPSTART = 3'h2,
    CMD_WRITE = 3'h3,
    CMD_READ = 3'h4,
    CMD_ACKOUT = 3'h5
  } cmd_t;
endpackage

// ==== hdl/smbus_link_if.sv ====
// Carrier between the register-side controller and the link engine.
// Request and done are toggles; rx_byte and arb_lost are only valid once done has toggled.
`timescale 1ns/1ps
`default_nettype none
interface smbus_link_if;
  smbus_pkg::cmd_t cmd;
  logic req_tgl;
  logic done_tgl;
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic ack_lvl;
  logic arb_lost;
  modport ctrl (output cmd, output req_tgl, output tx_byte, output ack_lvl,
                input done_tgl, input rx_byte, input arb_lost);
  modport link (input cmd, input req_tgl, input tx_byte, input ack_lvl,
                output done_tgl, output rx_byte, output arb_lost);
endinterface
`default_nettype wire

// ==== hdl/smbus_link_engine.sv ====
// Link-clock engine: drives SCL and SDA as open drain and watches the bus.
// Assumes link_clk runs free at six times the wanted bit rate, as each bit takes six link cycles.
`timescale 1ns/1ps
`default_nettype none
module smbus_link_engine #(
  parameter int unsigned TMO_CYC = smbus_pkg::BUS_IDLE_TIMEOUT_CYC,
  parameter int TMO_W = 16
) (
  input wire logic link_clk,
  input wire logic rst,
  smbus_link_if.link lk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_oe_n,
  output logic sda_oe_n,
  output logic pin_low
);
  typedef enum logic [3:0] {
    L_IDLE = 4'b0001, L_START = 4'b0010, L_STOP = 4'b0100, L_BIT = 4'b1000
  } lstate_t;
  lstate_t st_ff, nxt_st;
  logic rst_s1_ff, rst_ff, req_s1_ff, req_s2_ff, req_seen_ff, nxt_req_seen;
  logic scl_s1_ff, scl_s2_ff, sda_s1_ff, sda_s2_ff, sda_prev_ff;
  logic [1:0] q_ff, nxt_q;
  logic [3:0] nb_ff, nxt_nb;
  logic [8:0] tx_ff, nxt_tx;
  logic [7:0] rx_ff, nxt_rx;
  logic [TMO_W-1:0] tmo_ff, nxt_tmo;
  logic chain_ff, nxt_chain, arbchk_ff, nxt_arbchk, own_ff, nxt_own, busy_ff, nxt_busy;
  logic done_ff, nxt_done, arb_ff, nxt_arb, scl_oe_n_ff, nxt_scl_oe_n;
  logic sda_oe_n_ff, nxt_sda_oe_n, start_det, stop_det;

  always_ff @(posedge link_clk) begin
    rst_s1_ff <= rst;
    rst_ff <= rst_s1_ff;
    req_s1_ff <= lk.req_tgl;
    req_s2_ff <= req_s1_ff;
    scl_s1_ff <= scl_in;
    scl_s2_ff <= scl_s1_ff;
    sda_s1_ff <= sda_in;
    sda_s2_ff <= sda_s1_ff;
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_q = q_ff;
    nxt_nb = nb_ff;
    nxt_tx = tx_ff;
    nxt_rx = rx_ff;
    nxt_tmo = tmo_ff;
    nxt_chain = chain_ff;
    nxt_arbchk = arbchk_ff;
    nxt_own = own_ff;
    nxt_busy = busy_ff;
    nxt_done = done_ff;
    nxt_arb = arb_ff;
    nxt_scl_oe_n = scl_oe_n_ff;
    nxt_sda_oe_n = sda_oe_n_ff;
    nxt_req_seen = req_s2_ff;
    start_det = scl_s2_ff && sda_prev_ff && !sda_s2_ff;
    stop_det = scl_s2_ff && !sda_prev_ff && sda_s2_ff;
    if (start_det) begin
      nxt_busy = 1'b1;
      nxt_tmo = '0;
    end else if (stop_det) begin
      nxt_busy = 1'b0;
    end else if (busy_ff && scl_s2_ff && sda_s2_ff) begin
      nxt_tmo = tmo_ff + TMO_W'(1);
      if (tmo_ff == TMO_W'(TMO_CYC - 1)) begin
        nxt_busy = 1'b0;
        nxt_tmo = '0;
      end
    end else begin
      nxt_tmo = '0;
    end
    unique case (st_ff)
      L_IDLE: begin
        if (req_s2_ff != req_seen_ff) begin
          nxt_q = 2'h0;
          nxt_arb = 1'b0;
          nxt_chain = 1'b0;
          nxt_arbchk = 1'b0;
          nxt_tx = 9'h1ff;
          nxt_rx = '0;
          case (lk.cmd)
            smbus_pkg::CMD_START: nxt_st = L_START;
            smbus_pkg::CMD_STOP: nxt_st = L_STOP;
            smbus_pkg::CMD_STOPSTART: begin
              nxt_st = L_STOP;
              nxt_chain = 1'b1;
            end
            smbus_pkg::CMD_WRITE: begin
              nxt_st = L_BIT;
              nxt_tx = {lk.tx_byte, 1'b1};
              nxt_nb = 4'(smbus_pkg::TX_BITS);
              nxt_arbchk = 1'b1;
            end
            smbus_pkg::CMD_READ: begin
              nxt_st = L_BIT;
              nxt_nb = 4'(smbus_pkg::RX_BITS);
            end
            smbus_pkg::CMD_ACKOUT: begin
              nxt_st = L_BIT;
              nxt_tx = {!lk.ack_lvl, 8'hff};
              nxt_nb = 4'(smbus_pkg::ACK_BITS);
            end
            default: nxt_done = !done_ff;
          endcase
        end
      end
      L_START: begin
        unique case (q_ff)
          2'h0: if (chain_ff || own_ff || !busy_ff) begin
            nxt_sda_oe_n = 1'b1;
            nxt_q = 2'h1;
          end
          2'h1: begin
            nxt_scl_oe_n = 1'b1;
            nxt_q = 2'h2;
          end
          2'h2: if (scl_s2_ff) begin
            if (!sda_s2_ff) begin
              nxt_arb = 1'b1;
              nxt_own = 1'b0;
              nxt_st = L_IDLE;
              nxt_done = !done_ff;
            end else begin
              nxt_sda_oe_n = 1'b0;
              nxt_q = 2'h3;
            end
          end
          2'h3: begin
            nxt_scl_oe_n = 1'b0;
            nxt_own = 1'b1;
            nxt_st = L_IDLE;
            nxt_done = !done_ff;
          end
        endcase
      end
      L_STOP: begin
        unique case (q_ff)
          2'h0: begin
            nxt_sda_oe_n = 1'b0;
            nxt_q = 2'h1;
          end
          2'h1: begin
            nxt_scl_oe_n = 1'b1;
            nxt_q = 2'h2;
          end
          2'h2: if (scl_s2_ff) begin
            nxt_sda_oe_n = 1'b1;
            nxt_q = 2'h3;
          end
          2'h3: begin
            nxt_own = 1'b0;
            nxt_q = 2'h0;
            nxt_st = chain_ff ? L_START : L_IDLE;
            nxt_done = chain_ff ? done_ff : !done_ff;
          end
        endcase
      end
      L_BIT: begin
        unique case (q_ff)
          2'h0: begin
            nxt_sda_oe_n = tx_ff[8];
            nxt_q = 2'h1;
          end
          2'h1: begin
            nxt_scl_oe_n = 1'b1;
            nxt_q = 2'h2;
          end
          2'h2: if (scl_s2_ff) begin
            nxt_rx = {rx_ff[6:0], sda_s2_ff};
            nxt_q = 2'h3;
            if (arbchk_ff && tx_ff[8] && !sda_s2_ff && nb_ff != 4'h1) begin
              nxt_arb = 1'b1;
              nxt_own = 1'b0;
              nxt_sda_oe_n = 1'b1;
              nxt_st = L_IDLE;
              nxt_done = !done_ff;
            end
          end
          2'h3: begin
            nxt_scl_oe_n = 1'b0;
            nxt_tx = {tx_ff[7:0], 1'b1};
            nxt_nb = nb_ff - 4'h1;
            nxt_q = 2'h0;
            if (nb_ff == 4'h1) begin
              nxt_st = L_IDLE;
              nxt_done = !done_ff;
            end
          end
        endcase
      end
      default: nxt_st = L_IDLE;
    endcase
  end

  always_ff @(posedge link_clk) begin
    if (rst_ff) begin
      st_ff <= L_IDLE;
      q_ff <= 2'h0;
      nb_ff <= 4'h0;
      tx_ff <= 9'h1ff;
      rx_ff <= 8'h00;
      tmo_ff <= '0;
      chain_ff <= 1'b0;
      arbchk_ff <= 1'b0;
      own_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      arb_ff <= 1'b0;
      scl_oe_n_ff <= 1'b1;
      sda_oe_n_ff <= 1'b1;
      req_seen_ff <= 1'b0;
      sda_prev_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      q_ff <= nxt_q;
      nb_ff <= nxt_nb;
      tx_ff <= nxt_tx;
      rx_ff <= nxt_rx;
      tmo_ff <= nxt_tmo;
      chain_ff <= nxt_chain;
      arbchk_ff <= nxt_arbchk;
      own_ff <= nxt_own;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      arb_ff <= nxt_arb;
      scl_oe_n_ff <= nxt_scl_oe_n;
      sda_oe_n_ff <= nxt_sda_oe_n;
      req_seen_ff <= nxt_req_seen;
      sda_prev_ff <= sda_s2_ff;
    end
  end

  assign lk.done_tgl = done_ff;
  assign lk.rx_byte = rx_ff;
  assign lk.arb_lost = arb_ff;
  assign scl_oe_n = scl_oe_n_ff;
  assign sda_oe_n = sda_oe_n_ff;
  assign pin_low = 1'b0;

  property p_start_waits_busy;
    @(posedge link_clk) disable iff (rst_ff)
    (st_ff == L_START && q_ff == 2'h0 && busy_ff && !own_ff && !chain_ff)
      |=> st_ff == L_START && q_ff == 2'h0 && sda_oe_n_ff;
  endproperty
  a_start_waits_busy: assert property (p_start_waits_busy) else $error("start left busy bus");

  property p_idle_holds_scl;
    @(posedge link_clk) disable iff (rst_ff)
    (st_ff == L_IDLE && own_ff) |-> !scl_oe_n_ff;
  endproperty
  a_idle_holds_scl: assert property (p_idle_holds_scl) else $error("scl released in stall");
endmodule // smbus_link_engine
`default_nettype wire

// ==== hdl/smbus_master_receive_control.sv ====
// Register-side control of the two-wire bus master with its link engine.
// Assumes a single-cycle register port on ref_clk and open-drain pins outside.
`timescale 1ns/1ps
`default_nettype none
module smbus_master_receive_control #(
  parameter int unsigned TMO_CYC = smbus_pkg::BUS_IDLE_TIMEOUT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic [smbus_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_n,
  output logic sda_out,
  output logic sda_oe_n
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b001, S_WAIT = 3'b010, S_STALL = 3'b100
  } cstate_t;
  cstate_t state_ff, nxt_state;
  smbus_pkg::cmd_t cmd_ff, nxt_cmd, go_cmd;
  logic master_ff, nxt_master, transmit_direction_flag_ff, nxt_transmit_direction_flag, sta_ff, nxt_sta;
  logic sto_ff, nxt_sto, ack_request_flag_ff, nxt_ack_request_flag, arbitration_lost_flag_ff, nxt_arbitration_lost_flag;
  logic ack_ff, nxt_ack, si_ff, nxt_si, addr_phase_ff, nxt_addr_phase;
  logic req_tgl_ff, nxt_req_tgl, ack_lvl_ff, nxt_ack_lvl;
  logic done_s1_ff, done_s2_ff, done_seen_ff, done_evt, go, pin_low;
  logic ctrl_wr, data_wr;
  logic [7:0] data_ff, nxt_data, rdata_ff, nxt_rdata, ctrl_view;
  smbus_link_if lk ();

  // Picks what follows an acknowledge or a cleared interrupt flag.
  function automatic smbus_pkg::cmd_t follow_cmd(input logic sta, input logic stop_request,
                                                 input logic tx);
    if (sta && stop_request) begin
      return smbus_pkg::CMD_STOPSTART;
    end else if (stop_request) begin
      return smbus_pkg::CMD_STOP;
    end else if (sta) begin
      return smbus_pkg::CMD_START;
    end else if (tx) begin
      return smbus_pkg::CMD_WRITE;
    end
    return smbus_pkg::CMD_READ;
  endfunction

  smbus_link_engine #(
    .TMO_CYC(TMO_CYC),
    .TMO_W(16)
  ) u_link (
    .link_clk(link_clk),
    .rst(rst),
    .lk(lk.link),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_oe_n(scl_oe_n),
    .sda_oe_n(sda_oe_n),
    .pin_low(pin_low)
  );

  assign lk.cmd = cmd_ff;
  assign lk.req_tgl = req_tgl_ff;
  assign lk.tx_byte = data_ff;
  assign lk.ack_lvl = ack_lvl_ff;
  assign scl_out = pin_low;
  assign sda_out = pin_low;
  assign rdata = rdata_ff;
  assign done_evt = done_s2_ff != done_seen_ff;
  assign ctrl_wr = wr_stb && addr == smbus_pkg::CTRL_STATUS_OFS;
  assign data_wr = wr_stb && addr == smbus_pkg::SERIAL_BYTE_OFS;
  assign ctrl_view = {master_ff, transmit_direction_flag_ff, sta_ff, sto_ff,
                      ack_request_flag_ff, arbitration_lost_flag_ff, ack_ff, si_ff};

  always_comb begin
    nxt_state = state_ff;
    nxt_cmd = cmd_ff;
    nxt_master = master_ff;
    nxt_transmit_direction_flag = transmit_direction_flag_ff;
    nxt_sta = sta_ff;
    nxt_sto = sto_ff;
    nxt_ack_request_flag = ack_request_flag_ff;
    nxt_arbitration_lost_flag = arbitration_lost_flag_ff;
    nxt_ack = ack_ff;
    nxt_si = si_ff;
    nxt_addr_phase = addr_phase_ff;
    nxt_req_tgl = req_tgl_ff;
    nxt_ack_lvl = ack_lvl_ff;
    nxt_data = data_ff;
    nxt_rdata = 8'h00;
    go = 1'b0;
    go_cmd = cmd_ff;
    if (rd_stb) begin
      nxt_rdata = addr == smbus_pkg::CTRL_STATUS_OFS ? ctrl_view :
                  addr == smbus_pkg::SERIAL_BYTE_OFS ? data_ff : 8'h00;
    end
    if (ctrl_wr) begin
      nxt_sta = wdata[smbus_pkg::POS_START];
      nxt_sto = wdata[smbus_pkg::POS_STOP];
      nxt_ack = wdata[smbus_pkg::POS_ACK];
    end
    if (data_wr) begin
      nxt_data = wdata;
      if (master_ff && !transmit_direction_flag_ff && !addr_phase_ff) begin
        nxt_transmit_direction_flag = 1'b1;
      end
    end
    unique case (state_ff)
      S_IDLE: begin
        nxt_sto = 1'b0;
        if (nxt_sta) begin
          go = 1'b1;
          go_cmd = smbus_pkg::CMD_START;
        end
      end
      S_STALL: begin
        if (ctrl_wr && !wdata[smbus_pkg::POS_SI]) begin
          nxt_si = 1'b0;
          go = 1'b1;
          if (ack_request_flag_ff) begin
            nxt_ack_request_flag = 1'b0;
            nxt_ack_lvl = nxt_ack;
            go_cmd = smbus_pkg::CMD_ACKOUT;
          end else if (!master_ff) begin
            go = nxt_sta;
            go_cmd = smbus_pkg::CMD_START;
          end else begin
            go_cmd = follow_cmd(nxt_sta, nxt_sto, nxt_transmit_direction_flag);
          end
          if (!go) begin
            nxt_state = S_IDLE;
          end
        end
      end
      S_WAIT: begin
        if (done_evt) begin
          nxt_state = S_STALL;
          nxt_si = 1'b1;
          unique case (cmd_ff)
            smbus_pkg::CMD_START, smbus_pkg::CMD_STOPSTART: begin
              nxt_sto = 1'b0;
              nxt_sta = 1'b0;
              nxt_master = 1'b1;
              nxt_transmit_direction_flag = 1'b1;
              nxt_addr_phase = 1'b1;
            end
            smbus_pkg::CMD_STOP: begin
              nxt_sto = 1'b0;
              nxt_master = 1'b0;
              nxt_transmit_direction_flag = 1'b0;
              nxt_si = 1'b0;
              nxt_state = S_IDLE;
            end
            smbus_pkg::CMD_WRITE: begin
              nxt_ack = !lk.rx_byte[0];
              nxt_addr_phase = 1'b0;
              if (addr_phase_ff) begin
                nxt_transmit_direction_flag = !data_ff[0];
              end
            end
            smbus_pkg::CMD_READ: begin
              nxt_data = lk.rx_byte;
              nxt_ack_request_flag = 1'b1;
            end
            smbus_pkg::CMD_ACKOUT: begin
              nxt_si = 1'b0;
              go = 1'b1;
              go_cmd = follow_cmd(nxt_sta, nxt_sto, nxt_transmit_direction_flag);
            end
            default: nxt_state = S_IDLE;
          endcase
          if (lk.arb_lost) begin
            nxt_arbitration_lost_flag = 1'b1;
            nxt_master = 1'b0;
            nxt_transmit_direction_flag = 1'b0;
            nxt_addr_phase = 1'b0;
            nxt_sta = 1'b0;
            nxt_si = 1'b1;
            nxt_state = S_STALL;
            go = 1'b0;
          end
        end
      end
      default: nxt_state = S_IDLE;
    endcase
    if (go) begin
      nxt_cmd = go_cmd;
      nxt_req_tgl = !req_tgl_ff;
      nxt_state = S_WAIT;
      if (go_cmd == smbus_pkg::CMD_START) begin
        nxt_arbitration_lost_flag = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    done_s1_ff <= lk.done_tgl;
    done_s2_ff <= done_s1_ff;
    if (rst) begin
      state_ff <= S_IDLE;
      cmd_ff <= smbus_pkg::CMD_START;
      {master_ff, transmit_direction_flag_ff, sta_ff, sto_ff} <= smbus_pkg::CTRL_STATUS_RESET[7:4];
      {ack_request_flag_ff, arbitration_lost_flag_ff, ack_ff, si_ff} <= smbus_pkg::CTRL_STATUS_RESET[3:0];
      addr_phase_ff <= 1'b0;
      req_tgl_ff <= 1'b0;
      ack_lvl_ff <= 1'b0;
      done_seen_ff <= 1'b0;
      data_ff <= smbus_pkg::SERIAL_BYTE_RESET;
      rdata_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      cmd_ff <= nxt_cmd;
      master_ff <= nxt_master;
      transmit_direction_flag_ff <= nxt_transmit_direction_flag;
      sta_ff <= nxt_sta;
      sto_ff <= nxt_sto;
      ack_request_flag_ff <= nxt_ack_request_flag;
      arbitration_lost_flag_ff <= nxt_arbitration_lost_flag;
      ack_ff <= nxt_ack;
      si_ff <= nxt_si;
      addr_phase_ff <= nxt_addr_phase;
      req_tgl_ff <= nxt_req_tgl;
      ack_lvl_ff <= nxt_ack_lvl;
      done_seen_ff <= done_s2_ff;
      data_ff <= nxt_data;
      rdata_ff <= nxt_rdata;
    end
  end

  // The link engine shares no edges with this domain, so every check of a link result keys off done_evt.
  property p_start_done;
    @(posedge ref_clk) disable iff (rst)
    (state_ff == S_WAIT && done_evt && cmd_ff == smbus_pkg::CMD_START && !lk.arb_lost)
      |=> si_ff && master_ff && transmit_direction_flag_ff && addr_phase_ff;
  endproperty
  a_start_done: assert property (p_start_done) else $error("start not followed by address");

  property p_read_dir;
    @(posedge ref_clk) disable iff (rst)
    (state_ff == S_WAIT && done_evt && cmd_ff == smbus_pkg::CMD_WRITE && addr_phase_ff
      && data_ff[0] && !lk.arb_lost) |=> !transmit_direction_flag_ff && master_ff;
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("read address kept transmit mode");

  property p_read_flags;
    @(posedge ref_clk) disable iff (rst)
    (state_ff == S_WAIT && done_evt && cmd_ff == smbus_pkg::CMD_READ)
      |=> ack_request_flag_ff && si_ff && state_ff == S_STALL;
  endproperty
  a_read_flags: assert property (p_read_flags) else $error("byte received without flags");

  property p_ack_level;
    @(posedge ref_clk) disable iff (rst)
    (state_ff == S_STALL && ack_request_flag_ff && ctrl_wr && !wdata[0])
      |=> cmd_ff == smbus_pkg::CMD_ACKOUT && ack_lvl_ff == $past(wdata[1]) && !ack_request_flag_ff;
  endproperty
  a_ack_level: assert property (p_ack_level) else $error("wrong acknowledge level");

  property p_stop_done;
    @(posedge ref_clk) disable iff (rst)
    (state_ff == S_WAIT && done_evt && cmd_ff == smbus_pkg::CMD_STOP)
      |=> !sto_ff && !master_ff && state_ff == S_IDLE;
  endproperty
  a_stop_done: assert property (p_stop_done) else $error("stop did not end master mode");

  property p_rx_to_tx;
    @(posedge ref_clk) disable iff (rst)
    (data_wr && master_ff && !transmit_direction_flag_ff && !addr_phase_ff && state_ff == S_STALL)
      |=> transmit_direction_flag_ff;
  endproperty
  a_rx_to_tx: assert property (p_rx_to_tx) else $error("data write kept receive mode");

  property p_si_stalls;
    @(posedge ref_clk) disable iff (rst)
    si_ff |-> state_ff == S_STALL && req_tgl_ff == done_s2_ff;
  endproperty
  a_si_stalls: assert property (p_si_stalls) else $error("link moved while flag set");

  property p_arb_lost;
    @(posedge ref_clk) disable iff (rst)
    (state_ff == S_WAIT && done_evt && lk.arb_lost)
      |=> arbitration_lost_flag_ff && si_ff && !master_ff;
  endproperty
  a_arb_lost: assert property (p_arb_lost) else $error("arbitration loss not flagged");

  property p_stop_start;
    @(posedge ref_clk) disable iff (rst)
    (state_ff == S_WAIT && done_evt && cmd_ff == smbus_pkg::CMD_ACKOUT && sta_ff && sto_ff
      && !ctrl_wr && !lk.arb_lost) |=> cmd_ff == smbus_pkg::CMD_STOPSTART ##1 state_ff == S_WAIT;
  endproperty
  a_stop_start: assert property (p_stop_start) else $error("stop then start not issued");

  property p_rep_start;
    @(posedge ref_clk) disable iff (rst)
    (state_ff == S_WAIT && done_evt && cmd_ff == smbus_pkg::CMD_ACKOUT && sta_ff && !sto_ff
      && !ctrl_wr && !lk.arb_lost) |=> cmd_ff == smbus_pkg::CMD_START && !si_ff;
  endproperty
  a_rep_start: assert property (p_rep_start) else $error("repeated start not issued");
endmodule // smbus_master_receive_control
`default_nettype wire

// ==== tb/smbus_slave_model.sv ====
// Behavioural slave on the two-wire bus: acknowledges its address and sends counting bytes.
// Assumes pull-ups on both lines and never stretches the clock.
`timescale 1ns/1ps
`default_nettype none
module smbus_slave_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_pull
);
  logic [7:0] addr_byte = 8'h00;
  logic [7:0] tx_byte = 8'ha5;
  logic [7:0] acks = 8'h00;
  logic mack = 1'b1;
  int stops = 0;
  initial sda_pull = 1'b0;
  always @(posedge sda) if (scl === 1'b1) stops++;
  // A restart inside a frame is not followed, so the scenarios issue no repeated START inside a frame.
  always @(negedge sda) if (scl === 1'b1) begin
    for (int i = 0; i < 8; i++) @(posedge scl) addr_byte = {addr_byte[6:0], sda};
    @(negedge scl);
    sda_pull = (addr_byte[7:1] == DEV_ADDR);
    @(negedge scl);
    if (addr_byte[0] && addr_byte[7:1] == DEV_ADDR) begin
      mack = 1'b1;
      while (mack) begin
        for (int i = 7; i >= 0; i--) begin
          sda_pull = ~tx_byte[i];
          @(negedge scl);
        end
        sda_pull = 1'b0;
        @(posedge scl) mack = ~sda;
        acks++;
        @(negedge scl);
        tx_byte = tx_byte + 8'h01;
      end
    end
    sda_pull = 1'b0;
  end
endmodule // smbus_slave_model
`default_nettype wire

// ==== tb/tb_smbus_master_receive_control.sv ====
// Bench for the two-wire master: register port stimulus and a slave model on the pins.
// Assumes both lines have pull-ups and the link clock runs free.
`timescale 1ns/1ps
`default_nettype none
module tb_smbus_master_receive_control;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] rdata;
  logic scl_oe_n;
  logic sda_oe_n;
  logic sda_pull;
  logic ext_sda = 1'b0;
  logic [7:0] d;
  int fails = 0;
  int checks = 0;
  int s0;
  // Each row is a register index and its value after reset.
  logic [9:0] rows [4] = '{10'h000, 10'h100, 10'h200, 10'h300};
  wire scl_w = scl_oe_n;
  wire sda_w = sda_oe_n & ~sda_pull & ~ext_sda;
  always #12.5 ref_clk = ~ref_clk;
  initial begin
    #7;
    forever #32 link_clk = ~link_clk;
  end
  smbus_master_receive_control #(.TMO_CYC(16)) u_smbus_master_receive_control (
    .ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .scl_in(scl_w), .sda_in(sda_w),
    .scl_out(), .scl_oe_n(scl_oe_n), .sda_out(), .sda_oe_n(sda_oe_n));
  smbus_slave_model u_smbus_slave_model (.scl(scl_w), .sda(sda_w), .sda_pull(sda_pull));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    @(negedge ref_clk);
    v = rdata;
  endtask
  task automatic wait_si;
    for (int n = 0; n < 500; n++) begin
      rd(2'h0, d);
      if (d[0] === 1'b1) break;
    end
    if (d[0] !== 1'b1) fails++;
  endtask
  task automatic wrap_up;
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    wrap_up();
  end
  initial begin
    // The link side sees reset two link edges late and so also holds it past the release.
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    wr(2'h2, 8'hff);
    wr(2'h3, 8'hff);
    foreach (rows[i]) begin
      rd(rows[i][9:8], d);
      chk(d, rows[i][7:0]);
    end
    @(negedge ref_clk) chk(rdata, 8'h00);
    wr(2'h0, 8'h20);
    wait_si();
    chk(d & 8'hfd, 8'hc1);
    chk({7'h0, scl_w}, 8'h00);
    wr(2'h1, 8'h55);
    wr(2'h0, 8'h00);
    wait_si();
    chk(d, 8'h83);
    chk(u_smbus_slave_model.addr_byte, 8'h55);
    wr(2'h0, 8'h00);
    wait_si();
    chk(d & 8'hfd, 8'h89);
    chk(u_smbus_slave_model.acks, 8'h00);
    chk({7'h0, scl_w}, 8'h00);
    rd(2'h1, d);
    chk(d, 8'ha5);
    wr(2'h0, 8'h02);
    wait_si();
    chk(d & 8'hfd, 8'h89);
    chk({7'h0, u_smbus_slave_model.mack}, 8'h01);
    rd(2'h1, d);
    chk(d, 8'ha6);
    s0 = u_smbus_slave_model.stops;
    wr(2'h0, 8'h10);
    for (int n = 0; n < 2000; n++) begin
      @(posedge ref_clk);
      if (u_smbus_slave_model.stops > s0) break;
    end
    chk({7'h0, u_smbus_slave_model.mack}, 8'h00);
    chk(8'(u_smbus_slave_model.stops - s0), 8'h01);
    repeat (8) @(posedge ref_clk);
    rd(2'h0, d);
    chk(d & 8'hfd, 8'h00);
    // A START from another master makes the bus busy, so a request must wait for its STOP.
    @(posedge ref_clk);
    ext_sda <= 1'b1;
    repeat (20) @(posedge ref_clk);
    wr(2'h0, 8'h20);
    repeat (40) @(posedge ref_clk);
    rd(2'h0, d);
    chk(d & 8'hfd, 8'h20);
    chk({7'h0, scl_w}, 8'h01);
    @(posedge ref_clk);
    ext_sda <= 1'b0;
    wait_si();
    chk(d & 8'hfd, 8'hc1);
    wrap_up();
  end
endmodule // tb_smbus_master_receive_control
`default_nettype wire
